// File: src/led_mode_pkg.sv
/*
  Constants and types shared by the LED driver mode and enable logic.
  Assumes a single 200 MHz clock domain with synchronous active-high reset.
*/
package led_mode_pkg;

  localparam int unsigned CLK_PERIOD_PS = 5000;

  // ****************************************************************
  // Timer interval (stands in for the capacitor-set interval)
  // ****************************************************************
  localparam int unsigned TIMER_MS      = 10;
  // Divide first: the plain product would overflow 32 bits
  localparam int unsigned TIMER_CYCLES  = TIMER_MS * (1000000000 / CLK_PERIOD_PS);
  localparam int unsigned TIMER_WIDTH   = 24;

  // ****************************************************************
  // Wake filter: first backlight enable pulse must exceed this; flash enable skips it
  // ****************************************************************
  localparam int unsigned WAKE_NS       = 8000;
  localparam int unsigned WAKE_CYCLES   = (WAKE_NS * 1000 + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS;

  // ****************************************************************
  // Switching oscillator
  // ****************************************************************
  localparam int unsigned SW_PERIOD_CYCLES = 167;
  localparam int unsigned SW_MAX_ON_CYCLES = 158;
  localparam int unsigned SW_CNT_WIDTH     = 8;

  localparam logic [1:0]  RESET_MODE = 2'h0;

  typedef enum logic [1:0] {
    MODE_OFF,
    MODE_BACKLIGHT,
    MODE_PREVIEW,
    MODE_FLASH
  } mode_t;

  typedef enum logic [1:0] {
    ST_SHUTDOWN,
    ST_WAKE,
    ST_SOFTSTART,
    ST_ACTIVE
  } power_state_t;

endpackage

// File: src/boost_switch_ctrl.sv
/*
  Fixed-frequency boost switch gate control with cycle-by-cycle current limit.
  Assumes currentLimit and overVoltage are synchronous comparator flags.
*/
`timescale 1ns/1ps
module boost_switch_ctrl (
  input  wire logic clk,
  input  wire logic reset,
  input  wire logic run,
  input  wire logic currentLimit,
  input  wire logic overVoltage,
  output logic      boostSwitchNode
);

  logic [led_mode_pkg::SW_CNT_WIDTH-1:0] phase_reg;
  logic                                  cutoff_reg;

  // ****************************************************************
  // Constant-frequency phase counter
  // ****************************************************************
  always_ff @(posedge clk) begin
    if (reset || !run) begin
      phase_reg <= '0;
    end else if (phase_reg == led_mode_pkg::SW_CNT_WIDTH'(led_mode_pkg::SW_PERIOD_CYCLES - 1)) begin
      phase_reg <= '0;
    end else begin
      phase_reg <= phase_reg + 1'b1;
    end
  end

  // Limit ends the on-phase for the rest of this cycle only
  always_ff @(posedge clk) begin
    if (reset || !run || phase_reg == led_mode_pkg::SW_CNT_WIDTH'(led_mode_pkg::SW_PERIOD_CYCLES - 1)) begin
      cutoff_reg <= 1'b0;
    end else if (currentLimit) begin
      cutoff_reg <= 1'b1;
    end
  end

  // Overvoltage kills the gate at once
  always_ff @(posedge clk) begin
    if (reset) begin
      boostSwitchNode <= 1'b0;
    end else begin
      boostSwitchNode <= run && !overVoltage && !currentLimit && !cutoff_reg
                         && phase_reg < led_mode_pkg::SW_CNT_WIDTH'(led_mode_pkg::SW_MAX_ON_CYCLES);
    end
  end

endmodule

// File: src/led_driver_mode_enable_logic.sv
/*
  Mode selection and enable timing of a boost LED driver: two host enables,
  shared soft-start/PWM timer, overvoltage shutdown and switch control.
  Assumes enables and comparator flags are synchronous to clk.
*/
`timescale 1ns/1ps
module led_driver_mode_enable_logic #(
  parameter logic [23:0] TIMER_TERMINAL = 24'(led_mode_pkg::TIMER_CYCLES)
) (
  input  wire logic clk,
  input  wire logic reset,
  input  wire logic backlightEnable,
  input  wire logic flashEnable,
  input  wire logic overVoltage,
  input  wire logic currentLimit,
  output logic      backlightStringA,
  output logic      backlightStringB,
  output logic      flashPreview,
  output logic      flashFull,
  output logic      softStartActive,
  output logic      converterOn,
  output logic      boostSwitchNode,
  output led_mode_pkg::mode_t modeState
);

  led_mode_pkg::power_state_t powerState_reg;
  logic [led_mode_pkg::TIMER_WIDTH-1:0] timer_reg;
  logic [12:0]                          wake_reg;
  logic                                 flashEnablePrev_reg;
  logic                                 blFiltered_reg;
  logic                                 ovpLatched_reg;
  logic                                 flashEdge;
  logic                                 timerDone;
  logic                                 anyEnable;
  led_mode_pkg::mode_t                  mode_next;

  // ****************************************************************
  // Decode helpers
  // ****************************************************************
  // Modes in which the backlight sinks may pass the raw enable through
  function automatic logic backlightMode(input led_mode_pkg::mode_t mode);
    return mode == led_mode_pkg::MODE_BACKLIGHT || mode == led_mode_pkg::MODE_PREVIEW;
  endfunction

  // Converter powered and modes driven; modes show during the ramp too
  function automatic logic poweredState(input led_mode_pkg::power_state_t state);
    return state == led_mode_pkg::ST_SOFTSTART || state == led_mode_pkg::ST_ACTIVE;
  endfunction

  // ****************************************************************
  // Enable edge detect
  // ****************************************************************
  // Reset level matches the idle low pin, so no false edge after reset
  assign flashEdge = flashEnable != flashEnablePrev_reg;
  assign timerDone = timer_reg >= TIMER_TERMINAL;
  assign anyEnable = backlightEnable || flashEnable;

  always_ff @(posedge clk) begin
    if (reset) begin
      flashEnablePrev_reg <= 1'b0;
    end else begin
      flashEnablePrev_reg <= flashEnable;
    end
  end

  // ****************************************************************
  // Power sequencing
  // ****************************************************************
  always_ff @(posedge clk) begin
    if (reset) begin
      powerState_reg <= led_mode_pkg::ST_SHUTDOWN;
    end else begin
      unique case (powerState_reg)
        led_mode_pkg::ST_SHUTDOWN: begin
          if (flashEnable) begin
            powerState_reg <= led_mode_pkg::ST_SOFTSTART;
          end else if (backlightEnable) begin
            powerState_reg <= led_mode_pkg::ST_WAKE;
          end
        end
        led_mode_pkg::ST_WAKE: begin
          // Wake filter guards against noise; host keeps first pulse long
          if (!anyEnable) begin
            powerState_reg <= led_mode_pkg::ST_SHUTDOWN;
          end else if (wake_reg >= 13'(led_mode_pkg::WAKE_CYCLES)) begin
            powerState_reg <= led_mode_pkg::ST_SOFTSTART;
          end
        end
        led_mode_pkg::ST_SOFTSTART: begin
          if (timerDone) begin
            powerState_reg <= led_mode_pkg::ST_ACTIVE;
          end
        end
        led_mode_pkg::ST_ACTIVE: begin
          // Shutdown once enables are low for a full interval; a flash edge ends the interval at once
          if (!anyEnable && !blFiltered_reg && timerDone) begin
            powerState_reg <= led_mode_pkg::ST_SHUTDOWN;
          end
        end
      endcase
    end
  end

  always_ff @(posedge clk) begin
    if (reset || powerState_reg != led_mode_pkg::ST_WAKE) begin
      wake_reg <= '0;
    end else if (wake_reg != '1) begin
      wake_reg <= wake_reg + 1'b1;
    end
  end

  // ****************************************************************
  // Shared soft-start / PWM timer
  // ****************************************************************
  // One counter: ramp length while starting, low-interval filter after
  always_ff @(posedge clk) begin
    if (reset) begin
      timer_reg <= '0;
    end else if (!poweredState(powerState_reg)) begin
      timer_reg <= '0;
    end else if (powerState_reg == led_mode_pkg::ST_SOFTSTART) begin
      if (!timerDone) begin
        timer_reg <= timer_reg + 1'b1;
      end
    end else if (flashEdge) begin
      timer_reg <= TIMER_TERMINAL;
    end else if (backlightEnable) begin
      timer_reg <= '0;
    end else if (!timerDone) begin
      timer_reg <= timer_reg + 1'b1;
    end
  end

  // Filtered backlight level rides out short PWM lows
  always_ff @(posedge clk) begin
    if (reset) begin
      blFiltered_reg <= 1'b0;
    end else if (backlightEnable) begin
      blFiltered_reg <= 1'b1;
    end else if (powerState_reg != led_mode_pkg::ST_ACTIVE || flashEdge || timerDone) begin
      blFiltered_reg <= 1'b0;
    end
  end

  // ****************************************************************
  // Overvoltage latch
  // ****************************************************************
  // Latched until full shutdown, since output stays high after trip
  // A trip in the shutdown cycle itself wins over the clear
  always_ff @(posedge clk) begin
    if (reset) begin
      ovpLatched_reg <= 1'b0;
    end else if (overVoltage) begin
      ovpLatched_reg <= 1'b1;
    end else if (powerState_reg == led_mode_pkg::ST_SHUTDOWN) begin
      ovpLatched_reg <= 1'b0;
    end
  end

  // ****************************************************************
  // Mode decode and outputs
  // ****************************************************************
  always_comb begin
    mode_next = led_mode_pkg::MODE_OFF;
    if (poweredState(powerState_reg)) begin
      if (blFiltered_reg && flashEnable) begin
        mode_next = led_mode_pkg::MODE_PREVIEW;
      end else if (blFiltered_reg) begin
        mode_next = led_mode_pkg::MODE_BACKLIGHT;
      end else if (flashEnable) begin
        mode_next = led_mode_pkg::MODE_FLASH;
      end
    end
  end

  always_ff @(posedge clk) begin
    if (reset) begin
      modeState        <= led_mode_pkg::mode_t'(led_mode_pkg::RESET_MODE);
      backlightStringA <= 1'b0;
      backlightStringB <= 1'b0;
      flashPreview     <= 1'b0;
      flashFull        <= 1'b0;
      softStartActive  <= 1'b0;
      converterOn      <= 1'b0;
    end else begin
      modeState        <= mode_next;
      // Backlight sinks follow the raw enable for PWM; flash stays steady
      backlightStringA <= backlightEnable && backlightMode(mode_next);
      backlightStringB <= backlightEnable && backlightMode(mode_next);
      flashPreview     <= mode_next == led_mode_pkg::MODE_PREVIEW;
      flashFull        <= mode_next == led_mode_pkg::MODE_FLASH;
      softStartActive  <= powerState_reg == led_mode_pkg::ST_SOFTSTART;
      converterOn      <= mode_next != led_mode_pkg::MODE_OFF && !ovpLatched_reg && !overVoltage;
    end
  end

  // ****************************************************************
  // Switch control
  // ****************************************************************
  // Runs only while a mode is lit and no overvoltage is latched
  boost_switch_ctrl switchCtrl (
    .clk             (clk),
    .reset           (reset),
    .run             (converterOn),
    .currentLimit    (currentLimit),
    .overVoltage     (overVoltage),
    .boostSwitchNode (boostSwitchNode)
  );

endmodule

// File: dv/led_mode_monitor.sv
/*
  Port-level checker for the LED driver mode and enable logic.
  Assumes it is bound to the top module; one clock, synchronous reset.
*/
`timescale 1ns/1ps
module led_mode_monitor (
  input wire logic                clk,
  input wire logic                reset,
  input wire logic                backlightEnable,
  input wire logic                overVoltage,
  input wire logic                currentLimit,
  input wire logic                backlightStringA,
  input wire logic                backlightStringB,
  input wire logic                flashPreview,
  input wire logic                flashFull,
  input wire logic                converterOn,
  input wire logic                boostSwitchNode,
  input wire led_mode_pkg::mode_t modeState
);
  // ****************************************************************
  // Properties
  // ****************************************************************
  logic [7:0] onCnt;

  default clocking cb @(posedge clk); endclocking
  default disable iff (reset);

  // Saturates well above the limit so a stuck switch still fails
  always_ff @(posedge clk) begin
    if (reset || !boostSwitchNode) begin
      onCnt <= 8'h00;
    end else if (onCnt != 8'hff) begin
      onCnt <= onCnt + 8'h01;
    end
  end

  AST_BL_FOLLOWS_EN: assert property (
    backlightStringA |-> $past(backlightEnable)) else $error("backlight on without enable");
  AST_BL_PAIR: assert property (
    backlightStringA == backlightStringB) else $error("backlight strings differ");
  AST_FLASH_ONE_LEVEL: assert property (
    !(flashFull && flashPreview)) else $error("flash and preview together");
  AST_FLASH_BL_OFF: assert property (
    ($past(modeState) == led_mode_pkg::MODE_FLASH && modeState == led_mode_pkg::MODE_FLASH)
    |-> !backlightStringA) else $error("backlight lit in flash mode");
  AST_OFF_DARK: assert property (
    ($past(modeState) == led_mode_pkg::MODE_OFF && modeState == led_mode_pkg::MODE_OFF)
    |-> !flashFull && !flashPreview) else $error("flash lit while off");
  AST_OV_CONV: assert property (
    overVoltage |=> !converterOn) else $error("converter on after overvoltage");
  AST_OV_SWITCH: assert property (
    overVoltage |-> ##[1:2] !boostSwitchNode) else $error("switch on after overvoltage");
  AST_CL_END: assert property (
    currentLimit && boostSwitchNode |-> ##[1:2] !boostSwitchNode) else $error("limit ignored");
  AST_MAX_ON: assert property (
    onCnt <= 8'(led_mode_pkg::SW_MAX_ON_CYCLES)) else $error("switch on beyond max duty");
endmodule

// File: dv/host_model.sv
/*
  Host side of the two enable lines.
  Assumes the bench sets the requests at the falling clock edge.
*/
`timescale 1ns/1ps
module host_model (
  input  wire logic reqBl,
  input  wire logic reqFl,
  output logic      backlightEnable,
  output logic      flashEnable
);
  // Bench holds the first high request past the wake time
  // Slow preview-to-flash: PWM stopped, backlight held low
  assign backlightEnable = reqBl;
  assign flashEnable     = reqFl;
endmodule

// File: dv/tb.sv
/*
  Self-checking bench for the LED driver mode and enable logic.
  Assumes the short timer terminal below; wake time is the package value.
*/
`timescale 1ns/1ps
module tb;
  // ****************************************************************
  // Bench
  // ****************************************************************
  localparam int TT = 50;
  logic clk, reset, reqBl, reqFl, backlightEnable, flashEnable, overVoltage, currentLimit;
  logic backlightStringA, backlightStringB, flashPreview, flashFull;
  logic softStartActive, converterOn, boostSwitchNode;
  led_mode_pkg::mode_t modeState;
  int err_count, num_checks, cycles;

  host_model host (.reqBl(reqBl), .reqFl(reqFl), .backlightEnable(backlightEnable),
                   .flashEnable(flashEnable));
  led_driver_mode_enable_logic #(.TIMER_TERMINAL(24'(TT))) uut (
    .clk(clk), .reset(reset), .backlightEnable(backlightEnable), .flashEnable(flashEnable),
    .overVoltage(overVoltage), .currentLimit(currentLimit),
    .backlightStringA(backlightStringA), .backlightStringB(backlightStringB),
    .flashPreview(flashPreview), .flashFull(flashFull), .softStartActive(softStartActive),
    .converterOn(converterOn), .boostSwitchNode(boostSwitchNode), .modeState(modeState));

  task automatic chk(input logic [7:0] seen, input logic [7:0] exp);
    num_checks++;
    if (seen !== exp) begin
      err_count++;
      $display("[ERR] %0t seen %h expected %h", $time, seen, exp);
    end
  endtask

  task automatic step(input int n);
    repeat (n) @(negedge clk);
  endtask

  // Cycles with the switch on over the next n falling edges
  task automatic count_on(input int n, output int onCycles);
    onCycles = 0;
    repeat (n) begin
      step(1);
      if (boostSwitchNode === 1'b1) begin
        onCycles++;
      end
    end
  endtask

  task automatic end_of_test;
    $display("checks %0d errors %0d", num_checks, err_count);
    if (err_count == 0 && num_checks > 0) $display("RESULT: PASS");
    else $display("RESULT: FAIL");
    $finish;
  endtask

  task automatic s_backlight;
    chk(modeState, led_mode_pkg::MODE_OFF);
    chk(converterOn, 1'b0);
    reqBl = 1'b1;
    step(1620);
    chk(softStartActive, 1'b1);
    step(TT + 10);
    chk(softStartActive, 1'b0);
    chk(modeState, led_mode_pkg::MODE_BACKLIGHT);
    chk({backlightStringA, backlightStringB}, 2'b11);
    chk(flashPreview, 1'b0);
  endtask

  // One full period, then a one-cycle limit at the start of an on-phase
  task automatic s_switch;
    int onCycles;
    count_on(led_mode_pkg::SW_PERIOD_CYCLES, onCycles);
    chk(8'(onCycles), 8'(led_mode_pkg::SW_MAX_ON_CYCLES));
    while (boostSwitchNode !== 1'b0) begin
      step(1);
    end
    while (boostSwitchNode !== 1'b1) begin
      step(1);
    end
    currentLimit = 1'b1;
    step(1);
    currentLimit = 1'b0;
    count_on(160, onCycles);
    chk(8'(onCycles), 8'h00);
    count_on(led_mode_pkg::SW_PERIOD_CYCLES, onCycles);
    chk(8'(onCycles), 8'(led_mode_pkg::SW_MAX_ON_CYCLES));
  endtask

  task automatic s_preview_pwm;
    reqFl = 1'b1;
    step(5);
    chk(modeState, led_mode_pkg::MODE_PREVIEW);
    chk({flashPreview, backlightStringA}, 2'b11);
    currentLimit = 1'b1;
    repeat (3) begin
      reqBl = 1'b0;
      step(10);
      chk({backlightStringA, flashPreview}, 2'b01);
      chk(modeState, led_mode_pkg::MODE_PREVIEW);
      chk(boostSwitchNode, 1'b0);
      reqBl = 1'b1;
      step(10);
      chk(backlightStringA, 1'b1);
    end
    currentLimit = 1'b0;
  endtask

  task automatic s_slow_flash;
    reqBl = 1'b0;
    step(TT - 10);
    chk(modeState, led_mode_pkg::MODE_PREVIEW);
    step(20);
    chk(modeState, led_mode_pkg::MODE_FLASH);
    chk({flashFull, backlightStringA}, 2'b10);
  endtask

  task automatic s_toggle_flash;
    reqBl = 1'b1;
    step(5);
    chk(modeState, led_mode_pkg::MODE_PREVIEW);
    reqBl = 1'b0;
    reqFl = 1'b0;
    step(2);
    reqFl = 1'b1;
    step(8);
    chk(modeState, led_mode_pkg::MODE_FLASH);
    chk(flashFull, 1'b1);
  endtask

  task automatic s_overvoltage_off;
    step(TT + 10);
    chk(converterOn, 1'b1);
    overVoltage = 1'b1;
    step(2);
    chk(converterOn, 1'b0);
    chk(boostSwitchNode, 1'b0);
    overVoltage = 1'b0;
    step(3);
    chk(converterOn, 1'b0);
    reqFl = 1'b0;
    step(TT + 10);
    chk(modeState, led_mode_pkg::MODE_OFF);
    chk(converterOn, 1'b0);
  endtask

  initial begin
    clk = 1'b0;
    forever #2.5 clk = ~clk;
  end

  // Hang guard: the whole sequence needs about 2550 cycles
  always @(posedge clk) begin
    cycles++;
    if (cycles == 10000) begin
      err_count++;
      end_of_test();
    end
  end

  initial begin
    {reset, reqBl, reqFl, overVoltage, currentLimit} = 5'b10000;
    step(10);
    reset = 1'b0;
    step(1);
    s_backlight();
    s_switch();
    s_preview_pwm();
    s_slow_flash();
    s_toggle_flash();
    s_overvoltage_off();
    end_of_test();
  end
endmodule

bind led_driver_mode_enable_logic led_mode_monitor mon (
  .clk(clk), .reset(reset), .backlightEnable(backlightEnable), .overVoltage(overVoltage),
  .currentLimit(currentLimit), .backlightStringA(backlightStringA),
  .backlightStringB(backlightStringB), .flashPreview(flashPreview), .flashFull(flashFull),
  .converterOn(converterOn), .boostSwitchNode(boostSwitchNode), .modeState(modeState));
